// >>> btbc_consts.svh
/*
 Constants for the bit-invert / branch / call execute block: phase codes,
 opcode patterns, widths, step sizes, register offsets, field positions
 and reset values.
 Assumes it is included by its bare name from each design file that needs it.
*/
`ifndef BTBC_CONSTS_SVH
`define BTBC_CONSTS_SVH

// widths of the program counter, the data-memory address and the bus address
`define BTBC_PC_W 21
`define BTBC_DADDR_W 12
`define BTBC_AXI_AW 8

// phase codes of the instruction cycle, one clock each
`define BTBC_Q1 2'h0
`define BTBC_Q2 2'h1
`define BTBC_Q3 2'h2
`define BTBC_Q4 2'h3
`define BTBC_Q_STEP 2'h1

// opcode patterns, compared against the top bits of a word
`define BTBC_PAT_BITINV 4'h7
`define BTBC_PAT_BR_OVF 8'hE4
`define BTBC_PAT_BR_ZERO 8'hE0
`define BTBC_PAT_CALL 7'h76
`define BTBC_PAT_TAIL 4'hF

// program counter steps in bytes, and its reset value
`define BTBC_PC_STEP 21'h000002
`define BTBC_RET_STEP 21'h000004
`define BTBC_PC_RST 21'h000000

// bank used when the bank-select bit is clear
`define BTBC_ACCESS_BANK 4'h0

// register byte offsets
`define BTBC_REG_CTRL 8'h00
`define BTBC_REG_PC 8'h04
`define BTBC_REG_STATUS 8'h08
`define BTBC_REG_SHADOW 8'h0C
`define BTBC_REG_STACK 8'h10

// field positions and reset values
`define BTBC_CTRL_RUN 0
`define BTBC_CTRL_RST 1'b0

// bus responses
`define BTBC_RESP_OKAY 2'h0
`define BTBC_RESP_SLVERR 2'h2

`endif

// >>> btbc_pkg.sv
/*
 Types shared by the execute block and its decoder.
 Assumes nothing of its surroundings.
*/
package btbc_pkg;

   // instruction classes this block acts on
   typedef enum logic [2:0] {op_none, op_bit_invert, op_br_ovf, op_br_zero, op_call, op_call_tail} btbc_op_t;

   // instruction-cycle state
   typedef enum logic {st_exec, st_nop} btbc_state_t;

   // register selected by a bus address
   typedef enum logic [2:0] {reg_ctrl, reg_pc, reg_status, reg_shadow, reg_stack, reg_none} btbc_reg_t;

endpackage

// >>> btbc_decode.sv
/*
 Combinational decoder of one 16-bit program word into an instruction
 class and its fields.
 Assumes the word is stable on the clock of the instantiating module.
*/
`timescale 1ns/1ps
`default_nettype none
`include "btbc_consts.svh"

module btbc_decode
   import btbc_pkg::*;
(
   input wire logic [15:0] word, // program word
   output var btbc_op_t op, // decoded class
   output logic [2:0] bit_sel, // bit number of a bit invert
   output logic sel_a, // bank-select bit or shadow-save bit
   output logic [7:0] lit // file address, offset or low call target
);

   // class from the top bits; anything else is left to the rest of the core
   always_comb
   begin
      op = op_none;
      if (word[15:12] == `BTBC_PAT_BITINV)
         op = op_bit_invert;
      else if (word[15:8] == `BTBC_PAT_BR_OVF)
         op = op_br_ovf;
      else if (word[15:8] == `BTBC_PAT_BR_ZERO)
         op = op_br_zero;
      else if (word[15:9] == `BTBC_PAT_CALL)
         op = op_call;
      else if (word[15:12] == `BTBC_PAT_TAIL)
         op = op_call_tail; // executed alone it does nothing
   end

   // fields share positions across the classes
   assign bit_sel = word[11:9];
   assign sel_a = word[8];
   assign lit = word[7:0];

endmodule
`default_nettype wire

// >>> btbc_exec.sv
/*
 Execute block for bit invert, branch on overflow, branch on zero and the
 two-word subroutine call, with an AXI4-Lite slave for control and status.
 Assumes program and data memories answer one clock after their address
 changes, and that flags and core registers are on ref_clk.
*/
// Contract
// - bit invert flips bit b of the addressed byte, others kept, written back.
// - bit invert is 0111, bit number, bank bit, eight-bit file address.
// - bank bit 0 addresses the fixed access bank, ignoring bank select.
// - bank bit 1 forms address from bank select plus file address.
// - overflow branch taken only when overflow flag is one, else falls through.
// - overflow branch is 1110 0100 then eight-bit signed offset.
// - zero branch taken only when zero flag is one, else falls through.
// - zero branch is 1110 0000 then eight-bit signed offset.
// - taken branch target is incremented pc plus twice the signed offset.
// - taken branch adds a no-operation cycle; untaken leaves pc alone.
// - none of these instructions alter any arithmetic status flag.
// - call pushes its own address plus four onto the return stack.
// - call with save bit one copies work, flags, bank select to shadows.
// - call with save bit zero leaves all three shadows unchanged.
// - call loads the 20-bit target into pc bits 20 to 1, bit 0 zero.
// - target low byte from first word, bits 19:8 from second word.
// - call target may be any value across the full 20-bit range.
// - call takes two cycles, the second a no-operation.
`timescale 1ns/1ps
`default_nettype none
`include "btbc_consts.svh"

module btbc_exec
   import btbc_pkg::*;
(
   input wire logic ref_clk, // core clock, 100 MHz
   input wire logic rstn, // async reset, active low
   input wire logic [`BTBC_AXI_AW-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [`BTBC_AXI_AW-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic [`BTBC_PC_W-1:0] prog_addr, // program memory byte address
   input wire logic [15:0] prog_data, // program word at prog_addr
   output logic [`BTBC_DADDR_W-1:0] dmem_addr, // data memory address
   output logic dmem_re, // data read strobe
   input wire logic [7:0] dmem_rdata, // data read byte
   output logic [7:0] dmem_wdata, // data write byte
   output logic dmem_we, // data write strobe
   input wire logic zero_flag, // zero status flag
   input wire logic ovf_flag, // overflow status flag
   input wire logic [7:0] work_reg, // working register
   input wire logic [7:0] status_reg, // status register
   input wire logic [7:0] bank_select_reg, // bank select register
   output logic stack_push, // return stack push strobe
   output logic [`BTBC_PC_W-1:0] stack_data, // return address pushed
   input wire logic [`BTBC_PC_W-1:0] stack_top, // current top of stack
   output logic [7:0] work_reg_shadow, // working register shadow
   output logic [7:0] flags_shadow, // status shadow
   output logic [7:0] bank_select_shadow // bank select shadow
);

   logic [1:0] q;
   logic run;
   btbc_state_t state;
   logic [15:0] ir;
   logic [`BTBC_PC_W-1:0] pc;
   logic [`BTBC_PC_W-1:0] instr_addr;
   btbc_op_t now_op;
   btbc_op_t ir_op;
   logic [2:0] now_bit;
   logic [2:0] ir_bit;
   logic now_a;
   logic ir_a;
   logic [7:0] now_lit;
   logic [7:0] ir_lit;
   logic active;
   logic ex;
   logic idle;
   logic take;
   logic [`BTBC_PC_W-1:0] br_off;
   logic [`BTBC_PC_W-1:0] call_target;
   logic aw_held;
   logic w_held;
   logic [`BTBC_AXI_AW-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   btbc_reg_t wr_reg;
   logic pc_load;
   logic [31:0] pc_merged;

   // bus address to register; unaligned or unknown offsets select none
   function automatic btbc_reg_t reg_decode(input logic [`BTBC_AXI_AW-1:0] a);
      case (a)
         `BTBC_REG_CTRL: reg_decode = reg_ctrl;
         `BTBC_REG_PC: reg_decode = reg_pc;
         `BTBC_REG_STATUS: reg_decode = reg_status;
         `BTBC_REG_SHADOW: reg_decode = reg_shadow;
         `BTBC_REG_STACK: reg_decode = reg_stack;
         default: reg_decode = reg_none;
      endcase
   endfunction

   // byte-lane merge of a write into an old value
   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[i*8 +: 8] = nv[i*8 +: 8];
      end
      return r;
   endfunction

   // word being fetched steers the data read; the latched word steers the rest
   btbc_decode dec_now (
      .word(prog_data),
      .op(now_op),
      .bit_sel(now_bit),
      .sel_a(now_a),
      .lit(now_lit)
   );

   btbc_decode dec_ir (
      .word(ir),
      .op(ir_op),
      .bit_sel(ir_bit),
      .sel_a(ir_a),
      .lit(ir_lit)
   );

   // a started instruction cycle always finishes, even if run drops
   assign active = run || (q != `BTBC_Q1);
   assign ex = active && (state == st_exec);
   assign idle = !run && (q == `BTBC_Q1);
   // flags are only read here, never written
   assign take = ((ir_op == op_br_ovf) && ovf_flag) || ((ir_op == op_br_zero) && zero_flag);
   assign br_off = {{12{ir_lit[7]}}, ir_lit, 1'b0};
   assign call_target = {prog_data[11:0], ir_lit, 1'b0};
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_reg = reg_decode(aw_addr);
   assign pc_load = wr_fire && (wr_reg == reg_pc) && idle;
   assign pc_merged = strb_merge({11'h000, pc}, w_data, w_strb);

   // phase divider: four clocks per instruction cycle
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         q <= `BTBC_Q1;
      else if (active)
         q <= q + `BTBC_Q_STEP;
   end

   // second cycle of a taken branch or a call is a no-operation
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         state <= st_exec;
      else if (active && (q == `BTBC_Q4))
      begin
         unique case (state)
            st_exec:
            begin
               if (take || (ir_op == op_call))
                  state <= st_nop;
            end
            st_nop:
               state <= st_exec;
         endcase
      end
   end

   // fetch, increment and program counter writes
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ir <= 16'h0000;
         pc <= `BTBC_PC_RST;
         instr_addr <= `BTBC_PC_RST;
         prog_addr <= `BTBC_PC_RST;
      end
      else if (pc_load)
      begin
         pc <= {pc_merged[`BTBC_PC_W-1:1], 1'b0};
         prog_addr <= {pc_merged[`BTBC_PC_W-1:1], 1'b0};
      end
      else if (ex && (q == `BTBC_Q2))
      begin
         ir <= prog_data;
         instr_addr <= pc;
         pc <= pc + `BTBC_PC_STEP;
         prog_addr <= pc + `BTBC_PC_STEP; // also the second call word
      end
      else if (ex && (q == `BTBC_Q4))
      begin
         // untaken branch leaves the incremented pc untouched
         if (take)
         begin
            pc <= pc + br_off;
            prog_addr <= pc + br_off;
         end
         else if (ir_op == op_call)
         begin
            pc <= call_target;
            prog_addr <= call_target;
         end
      end
   end

   // read-modify-write of one data byte
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dmem_addr <= '0;
         dmem_re <= 1'b0;
         dmem_we <= 1'b0;
         dmem_wdata <= 8'h00;
      end
      else
      begin
         dmem_re <= ex && (q == `BTBC_Q2) && (now_op == op_bit_invert);
         dmem_we <= ex && (q == `BTBC_Q4) && (ir_op == op_bit_invert);
         if (ex && (q == `BTBC_Q2) && (now_op == op_bit_invert))
         begin
            if (now_a)
               dmem_addr <= {bank_select_reg[3:0], now_lit};
            else
               dmem_addr <= {`BTBC_ACCESS_BANK, now_lit};
         end
         if (ex && (q == `BTBC_Q4) && (ir_op == op_bit_invert))
            dmem_wdata <= dmem_rdata ^ (8'h01 << ir_bit);
      end
   end

   // return push and optional shadow save, both in the third phase
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stack_push <= 1'b0;
         stack_data <= `BTBC_PC_RST;
         work_reg_shadow <= 8'h00;
         flags_shadow <= 8'h00;
         bank_select_shadow <= 8'h00;
      end
      else
      begin
         stack_push <= ex && (q == `BTBC_Q3) && (ir_op == op_call);
         if (ex && (q == `BTBC_Q3) && (ir_op == op_call))
         begin
            stack_data <= instr_addr + `BTBC_RET_STEP;
            // save bit clear keeps the shadows as they were
            if (ir_a)
            begin
               work_reg_shadow <= work_reg;
               flags_shadow <= status_reg;
               bank_select_shadow <= bank_select_reg;
            end
         end
      end
   end

   // write channels: address and data taken in either order
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BTBC_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_reg == reg_none) ? `BTBC_RESP_SLVERR : `BTBC_RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // run control; pc writes are honoured only while stopped
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         run <= `BTBC_CTRL_RST;
      else if (wr_fire && (wr_reg == reg_ctrl) && w_strb[0])
         run <= w_data[`BTBC_CTRL_RUN];
   end

   // read channel, one read in flight
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `BTBC_RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `BTBC_RESP_OKAY;
            unique case (reg_decode(s_axi_araddr))
               reg_ctrl: s_axi_rdata <= {31'h00000000, run};
               reg_pc: s_axi_rdata <= {11'h000, pc};
               reg_status: s_axi_rdata <= {28'h0000000, state == st_nop, q, run};
               reg_shadow: s_axi_rdata <= {8'h00, bank_select_shadow, flags_shadow, work_reg_shadow};
               reg_stack: s_axi_rdata <= {11'h000, stack_top};
               reg_none:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `BTBC_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // helper views for the checks below
   logic [3:0] prog_top;
   logic [3:0] bank_lo;
   logic [11:0] prog_khi;
   assign prog_top = prog_data[15:12];
   assign bank_lo = bank_select_reg[3:0];
   assign prog_khi = prog_data[11:0];

   bit_toggle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      dmem_we |-> dmem_wdata == ($past(dmem_rdata) ^ (8'h01 << ir_bit)))
      else $error("bit invert wrote a wrong byte");

   toggle_decode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      dmem_re |-> ($past(prog_top) == `BTBC_PAT_BITINV) ##2 dmem_we)
      else $error("data access without a bit invert word");

   access_bank_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (dmem_re && !ir_a) |-> dmem_addr == {`BTBC_ACCESS_BANK, ir_lit})
      else $error("access bank address wrong");

   banked_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (dmem_re && ir_a) |-> dmem_addr == {$past(bank_lo), ir_lit})
      else $error("banked address wrong");

   ovf_branch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (ex && (q == `BTBC_Q4) && (ir_op == op_br_ovf))
      |=> pc == ($past(ovf_flag) ? $past(pc) + $past(br_off) : $past(pc)))
      else $error("overflow branch pc wrong");

   zero_branch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (ex && (q == `BTBC_Q4) && (ir_op == op_br_zero))
      |=> pc == ($past(zero_flag) ? $past(pc) + $past(br_off) : $past(pc)))
      else $error("zero branch pc wrong");

   branch_nop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (ex && (q == `BTBC_Q4) && take) |=> (state == st_nop) && (prog_addr == pc))
      else $error("taken branch skipped its idle cycle");

   nop_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      // pc moves on the edge that enters the idle cycle, and by a bus write while parked in it
      (state == st_nop) |-> !dmem_re && !dmem_we && !stack_push && ((q == `BTBC_Q1) || $stable(pc)))
      else $error("activity in a no-operation cycle");

   push_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      stack_push |-> (stack_data == instr_addr + `BTBC_RET_STEP) ##1 (pc[0] == 1'b0))
      else $error("return address wrong");

   shadow_save_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (stack_push && ir_a) |-> (work_reg_shadow == $past(work_reg)) && (flags_shadow == $past(status_reg))
      && (bank_select_shadow == $past(bank_select_reg)))
      else $error("shadow save missed");

   shadow_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !(stack_push && ir_a) |-> $stable(work_reg_shadow) && $stable(flags_shadow) && $stable(bank_select_shadow))
      else $error("shadow changed without a save");

   call_target_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (ex && (q == `BTBC_Q4) && (ir_op == op_call))
      |=> (pc == {$past(prog_khi), ir_lit, 1'b0}) && (state == st_nop))
      else $error("call target or idle cycle wrong");

endmodule
`default_nettype wire

// >>> btbc_far_side.sv
/*
 far-side model: program memory, data memory and return stack top.
 assumes the execute block's strobes are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module btbc_far_side
(
   input wire logic ref_clk, // core clock
   input wire logic [20:0] prog_addr, // fetch byte address
   output logic [15:0] prog_data, // fetched word
   input wire logic [11:0] dmem_addr, // data address
   input wire logic dmem_re, // read strobe
   output logic [7:0] dmem_rdata, // read byte
   input wire logic [7:0] dmem_wdata, // write byte
   input wire logic dmem_we, // write strobe
   input wire logic stack_push, // push strobe
   input wire logic [20:0] stack_data, // pushed address
   output logic [20:0] stack_top // top of stack
);
   logic [15:0] pmem [0:1048575];
   logic [7:0] dmem [0:4095];
   // fetch lags the address by one clock
   always_ff @(posedge ref_clk)
      prog_data <= pmem[prog_addr[20:1]];
   // byte holds one clock only, then turns over so a late sample shows
   always_ff @(posedge ref_clk)
      dmem_rdata <= dmem_re ? dmem[dmem_addr] : ~dmem_rdata;
   // plain always: the bench preloads this array too
   always @(posedge ref_clk)
      if (dmem_we)
         dmem[dmem_addr] <= dmem_wdata;
   always_ff @(posedge ref_clk)
      if (stack_push)
         stack_top <= stack_data;
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
 bench for the execute block: bus tasks, two programme runs, checks.
 assumes btbc_far_side answers memory and stack traffic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "btbc_consts.svh"
module tb_top;
   logic ref_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic zero_flag, ovf_flag, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic dmem_re, dmem_we, stack_push;
   logic [7:0] s_axi_awaddr, s_axi_araddr, work_reg, status_reg, bank_select_reg;
   logic [7:0] dmem_rdata, dmem_wdata, work_reg_shadow, flags_shadow, bank_select_shadow;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [20:0] prog_addr, stack_data, stack_top;
   logic [15:0] prog_data;
   logic [11:0] dmem_addr;
   int errors, compares;
   btbc_exec dut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_addr, .prog_data,
      .dmem_addr, .dmem_re, .dmem_rdata, .dmem_wdata, .dmem_we, .zero_flag, .ovf_flag, .work_reg,
      .status_reg, .bank_select_reg, .stack_push, .stack_data, .stack_top, .work_reg_shadow, .flags_shadow,
      .bank_select_shadow);
   btbc_far_side far (.ref_clk, .prog_addr, .prog_data, .dmem_addr, .dmem_re, .dmem_rdata, .dmem_wdata,
      .dmem_we, .stack_push, .stack_data, .stack_top);
   task automatic report_and_stop;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic hang;
      errors++;
      $display("unexpected hang at %0t", $time);
      report_and_stop();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want)
      begin
         errors++;
         $display("unexpected value at %0t: %h, wanted %h", $time, got, want);
      end
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge ref_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 100)
         hang();
      @(posedge ref_clk); // one edge between requests, so no strobe is driven twice in a step
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge ref_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 100)
         hang();
      @(posedge ref_clk); // one edge between requests, so no strobe is driven twice in a step
   endtask
   // run until the fetch reaches a loop address, then stop at a cycle boundary
   task automatic run_until(input logic [20:0] pc_loop);
      int n;
      wr(`BTBC_REG_CTRL, 32'h00000001, rs);
      for (n = 0; n < 2000 && prog_addr !== pc_loop; n++)
         @(posedge ref_clk);
      if (n == 2000)
         hang();
      wr(`BTBC_REG_CTRL, 32'h00000000, rs);
      for (n = 0; n < 100; n++)
      begin
         rdr(`BTBC_REG_STATUS, rd, rs);
         if (rd[2:0] === 3'h0)
            break;
      end
      if (n == 100)
         hang();
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 8'h00, 32'h00000000, 4'hF};
      {zero_flag, ovf_flag, work_reg, status_reg, bank_select_reg} = {1'b0, 1'b1, 8'h3C, 8'h12, 8'h03};
      errors = 0;
      compares = 0;
      rstn = 1'b0;
      // unwritten program words are lone tail words
      for (int i = 0; i < 1048576; i++)
         far.pmem[i] = 16'hFFFF;
      for (int i = 0; i < 4096; i++)
         far.dmem[i] = 8'h00;
      {far.dmem[12'h010], far.dmem[12'h320], far.dmem[12'h030]} = {8'h75, 8'h01, 8'h5A};
      // run A: invert, banked invert, zero branch not taken, overflow branch over sentinels, call with save
      {far.pmem[0], far.pmem[1], far.pmem[2], far.pmem[3]} = {16'h7810, 16'h7F20, 16'hE005, 16'hE403};
      {far.pmem[4], far.pmem[5], far.pmem[6], far.pmem[8]} = {16'h7030, 16'h7030, 16'h7030, 16'hF000};
      {far.pmem[7], far.pmem[8'h31]} = {16'hED30, 16'hE4FF};
      // run B: overflow branch not taken, call without save to the top, zero branch back onto itself
      {far.pmem[8'h40], far.pmem[8'h41], far.pmem[20'hFFFF0]} = {16'hE47F, 16'hECF0, 16'hE0FF};
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rdr(`BTBC_REG_PC, rd, rs);
      chk(rd, 32'h00000000);
      chk({bank_select_shadow, flags_shadow, work_reg_shadow}, 32'h00000000);
      wr(8'h40, 32'h00000001, rs);
      chk(rs, `BTBC_RESP_SLVERR);
      rdr(8'h40, rd, rs);
      chk(rd, 32'h00000000);
      chk(rs, `BTBC_RESP_SLVERR);
      run_until(21'h000064);
      chk(far.dmem[12'h010], 8'h65);
      chk({far.dmem[12'h320], far.dmem[12'h020]}, 16'h8100);
      chk(far.dmem[12'h030], 8'h5A);
      rdr(`BTBC_REG_PC, rd, rs);
      chk(rd, 32'h00000062);
      rdr(`BTBC_REG_STACK, rd, rs);
      chk(rd, 32'h00000012);
      rdr(`BTBC_REG_SHADOW, rd, rs);
      chk(rd, 32'h0003123C);
      // new core values must not reach the shadows on an unsaved call
      work_reg <= 8'hC3;
      status_reg <= 8'hED;
      bank_select_reg <= 8'h0C;
      zero_flag <= 1'b1;
      ovf_flag <= 1'b0;
      wr(`BTBC_REG_PC, 32'h00000080, rs);
      chk(rs, `BTBC_RESP_OKAY);
      run_until(21'h1FFFE2);
      rdr(`BTBC_REG_PC, rd, rs);
      chk(rd, 32'h001FFFE0);
      rdr(`BTBC_REG_STACK, rd, rs);
      chk(rd, 32'h00000086);
      rdr(`BTBC_REG_SHADOW, rd, rs);
      chk(rd, 32'h0003123C);
      chk(far.dmem[12'h030], 8'h5A);
      report_and_stop();
   end
endmodule
`default_nettype wire
